// ---- common/pbc_pkg.sv ----
// Constants for the basic control and status register pair of the PHY.
// Assumes a 10 MHz management clock and a 5-bit register index.
package pbc_pkg;
	// ==========================================================
	// Register indices
	localparam int         IDX_W    = 5;
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_STAT = 5'h01;

	// ==========================================================
	// Control field positions
	localparam int CTL_SRST    = 15;
	localparam int CTL_LOOP    = 14;
	localparam int CTL_SPEED   = 13;
	localparam int CTL_AN_EN   = 12;
	localparam int CTL_PWR_DN  = 11;
	localparam int CTL_AN_RST  = 9;
	localparam int CTL_DUPLEX  = 8;
	localparam int CTL_COL     = 7;

	// ==========================================================
	// Status field positions and fixed values
	localparam int         STA_ABIL_HI = 15;
	localparam int         STA_ABIL_LO = 11;
	localparam logic [4:0] STA_ABIL    = 5'h0f;
	localparam int         STA_AN_DONE = 5;
	localparam int         STA_RFAULT  = 4;
	localparam int         STA_AN_ABLE = 3;
	localparam int         STA_LINK    = 2;
	localparam int         STA_JABBER  = 1;
	localparam int         STA_EXT_CAP = 0;

	// ==========================================================
	// Reset values and timing
	localparam logic [15:0] DATA_ZERO     = 16'h0000;
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          SRST_TIME_NS  = 1000;
	localparam int          SRST_CYC      = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SRST_LOAD     = 4'(SRST_CYC - 1);
	localparam logic [1:0]  STRAP_WAIT    = 2'h2;

	// Soft reset sequencer states
	typedef enum logic [0:0] {
		PBC_IDLE = 1'b0,
		PBC_SRST = 1'b1
	} pbc_state_e;
endpackage : pbc_pkg

// ---- src/pbc_regs.sv ----
// Basic control and basic status registers of the integrated PHY.
// Assumes the MAC management access logic on REF_CLK drives index and strobes.
// What this block does
// RULE_01: Registers reached only through MAC management access
// RULE_02: Index 0 control, index 1 status
// RULE_03: Strap capture survives soft reset only
// RULE_04: Control bit 15 starts self-clearing soft reset
// RULE_05: Host writes reset bit alone
// RULE_06: Control bit 14 selects loopback
// RULE_07: Bit 13 forces speed unless negotiating
// RULE_08: Bit 12 enables negotiation, overrides forcing
// RULE_09: Speed and negotiation defaults from strap
// RULE_10: Control bit 11 selects power down
// RULE_11: Negotiation completion sets status bit 5
// RULE_12: Bit 9 restarts negotiation, self-clears
// RULE_13: Bit 8 forces duplex unless negotiating
// RULE_14: Bit 7 enables collision signal test
// RULE_15: Ability bits fixed: T4 zero, others one
// RULE_16: Status bit 5 shows negotiation complete
// RULE_17: Remote fault latches high until read
// RULE_18: Status bit 3 reads one
// RULE_19: Link status latches low until read
// RULE_20: Jabber latches high until read
// RULE_21: Status bit 0 reads one
// RULE_22: Read re-arms latches; reserved bits zero
`timescale 1ns/100ps
`default_nettype none
module pbc_regs (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic [4:0]  MGMT_INDEX,
	input  wire logic        MGMT_WR_STB,
	input  wire logic [15:0] MGMT_WR_DATA,
	input  wire logic        MGMT_RD_STB,
	output logic      [15:0] MGMT_RD_DATA,
	output logic             MGMT_RD_VALID,
	input  wire logic        SPEED_STRAP,
	input  wire logic        LINK_UP_IN,
	input  wire logic        REMOTE_FAULT_IN,
	input  wire logic        JABBER_IN,
	input  wire logic        AN_DONE_IN,
	output logic             SOFT_RESET_ACTIVE,
	output logic             LOOPBACK_EN,
	output logic             FORCE_SPEED_100,
	output logic             FORCE_FULL_DUPLEX,
	output logic             AN_ENABLE,
	output logic             AN_RESTART,
	output logic             POWER_DOWN,
	output logic             COL_TEST_EN
);
	// ==========================================================
	// Pin synchronisers
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;

	assign pin_raw = {SPEED_STRAP, LINK_UP_IN, REMOTE_FAULT_IN, JABBER_IN, AN_DONE_IN};

	// Two stages per pin; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= pin_raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	logic strap_s;
	logic link_live;
	logic rf_live;
	logic jab_live;
	logic an_done_s;
	assign {strap_s, link_live, rf_live, jab_live, an_done_s} = sync_b;

	// ==========================================================
	// Strap capture after hard reset release
	logic [1:0] strap_wait;
	logic       strap_ok;
	logic       strap_val;
	logic       strap_load;

	assign strap_load = !strap_ok && (strap_wait == pbc_pkg::STRAP_WAIT);

	// Only the hard reset clears this; a soft reset reloads from it
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			strap_wait <= 2'h0;
			strap_ok   <= 1'b0;
			strap_val  <= 1'b0;
		end else if (!strap_ok) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_load) begin
				strap_ok  <= 1'b1;
				strap_val <= strap_s; // RULE_03 RULE_09
			end
		end
	end

	// ==========================================================
	// Access decode
	logic access_ok;
	logic wr_ctl;
	logic rd_stat;
	logic srst_start;
	logic srst_active;
	assign access_ok  = strap_ok && !srst_active;
	// Writes to status or to unmapped indices are dropped
	assign wr_ctl     = MGMT_WR_STB && access_ok && (MGMT_INDEX == pbc_pkg::IDX_CTRL); // RULE_02
	assign rd_stat    = MGMT_RD_STB && (MGMT_INDEX == pbc_pkg::IDX_STAT); // RULE_02
	assign srst_start = wr_ctl && MGMT_WR_DATA[pbc_pkg::CTL_SRST];

	// ==========================================================
	// Soft reset sequencer
	pbc_pkg::pbc_state_e state;
	logic [3:0]          srst_cnt;

	// Holds the reset bit for a fixed time, then lets it clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state       <= pbc_pkg::PBC_IDLE;
			srst_cnt    <= 4'h0;
			srst_active <= 1'b0;
		end else begin
			case (state)
				pbc_pkg::PBC_IDLE: begin
					if (srst_start) begin
						state       <= pbc_pkg::PBC_SRST; // RULE_04
						srst_cnt    <= pbc_pkg::SRST_LOAD;
						srst_active <= 1'b1;
					end
				end
				pbc_pkg::PBC_SRST: begin
					if (srst_cnt == 4'h0) begin
						state       <= pbc_pkg::PBC_IDLE;
						srst_active <= 1'b0; // RULE_04
					end else begin
						srst_cnt <= srst_cnt - 4'h1;
					end
				end
				default: begin
					state       <= pbc_pkg::PBC_IDLE;
					srst_active <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Control fields
	logic ctl_loop;
	logic ctl_speed;
	logic ctl_an_en;
	logic ctl_pwr;
	logic ctl_duplex;
	logic ctl_col;
	logic an_restart;

	// A reset request discards the rest of the written word, so a host
	// that ignores the write-reset-alone advice still gets defaults
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctl_loop   <= 1'b0;
			ctl_speed  <= 1'b0;
			ctl_an_en  <= 1'b0;
			ctl_pwr    <= 1'b0;
			ctl_duplex <= 1'b0;
			ctl_col    <= 1'b0;
		end else if (strap_load || srst_start) begin
			ctl_loop   <= 1'b0; // RULE_05 RULE_06
			ctl_speed  <= strap_load ? strap_s : strap_val; // RULE_09
			ctl_an_en  <= strap_load ? strap_s : strap_val; // RULE_09
			ctl_pwr    <= 1'b0; // RULE_10
			ctl_duplex <= 1'b0; // RULE_13
			ctl_col    <= 1'b0; // RULE_14
		end else if (wr_ctl) begin
			ctl_loop   <= MGMT_WR_DATA[pbc_pkg::CTL_LOOP]; // RULE_06
			ctl_speed  <= MGMT_WR_DATA[pbc_pkg::CTL_SPEED]; // RULE_07
			ctl_an_en  <= MGMT_WR_DATA[pbc_pkg::CTL_AN_EN]; // RULE_08
			ctl_pwr    <= MGMT_WR_DATA[pbc_pkg::CTL_PWR_DN]; // RULE_10
			ctl_duplex <= MGMT_WR_DATA[pbc_pkg::CTL_DUPLEX]; // RULE_13
			ctl_col    <= MGMT_WR_DATA[pbc_pkg::CTL_COL]; // RULE_14
		end
	end

	// Restart pulse lasts one cycle, so the bit self-clears
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			an_restart <= 1'b0;
		end else begin
			an_restart <= wr_ctl && !MGMT_WR_DATA[pbc_pkg::CTL_SRST]
				&& MGMT_WR_DATA[pbc_pkg::CTL_AN_RST]; // RULE_12
		end
	end

	// ==========================================================
	// Mode outputs toward the PHY core
	// Forced speed and duplex outputs stay low while negotiation owns the link
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			LOOPBACK_EN       <= 1'b0;
			FORCE_SPEED_100   <= 1'b0;
			FORCE_FULL_DUPLEX <= 1'b0;
			AN_ENABLE         <= 1'b0;
			POWER_DOWN        <= 1'b0;
			COL_TEST_EN       <= 1'b0;
		end else begin
			LOOPBACK_EN       <= ctl_loop; // RULE_06
			FORCE_SPEED_100   <= ctl_speed && !ctl_an_en; // RULE_07
			FORCE_FULL_DUPLEX <= ctl_duplex && !ctl_an_en; // RULE_08 RULE_13
			AN_ENABLE         <= ctl_an_en; // RULE_08
			POWER_DOWN        <= ctl_pwr; // RULE_10
			COL_TEST_EN       <= ctl_col; // RULE_14
		end
	end

	assign AN_RESTART        = an_restart;
	assign SOFT_RESET_ACTIVE = srst_active;

	// ==========================================================
	// Status flags
	logic an_cmpl;
	logic rf_latch;
	logic link_latch;
	logic jab_latch;

	// Completion is dropped while powered down, restarting or in soft reset
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			an_cmpl <= 1'b0;
		end else begin
			an_cmpl <= an_done_s && ctl_an_en && !ctl_pwr && !an_restart
				&& !srst_active; // RULE_11 RULE_16
		end
	end

	// Latches: a live event in the read cycle wins over the re-arm
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rf_latch   <= 1'b0;
			link_latch <= 1'b0;
			jab_latch  <= 1'b0;
		end else if (srst_start) begin
			rf_latch   <= 1'b0;
			link_latch <= 1'b0;
			jab_latch  <= 1'b0;
		end else begin
			rf_latch   <= rf_live || (rf_latch && !rd_stat); // RULE_17 RULE_22
			link_latch <= rd_stat ? link_live : (link_latch && link_live); // RULE_19 RULE_22
			jab_latch  <= jab_live || (jab_latch && !rd_stat); // RULE_20 RULE_22
		end
	end

	// ==========================================================
	// Read path
	logic [15:0] ctl_word;
	logic [15:0] stat_word;

	always_comb begin
		ctl_word = pbc_pkg::DATA_ZERO; // RULE_22
		ctl_word[pbc_pkg::CTL_SRST]   = srst_active;
		ctl_word[pbc_pkg::CTL_LOOP]   = ctl_loop;
		ctl_word[pbc_pkg::CTL_SPEED]  = ctl_speed;
		ctl_word[pbc_pkg::CTL_AN_EN]  = ctl_an_en;
		ctl_word[pbc_pkg::CTL_PWR_DN] = ctl_pwr;
		ctl_word[pbc_pkg::CTL_AN_RST] = an_restart;
		ctl_word[pbc_pkg::CTL_DUPLEX] = ctl_duplex;
		ctl_word[pbc_pkg::CTL_COL]    = ctl_col;
	end

	always_comb begin
		stat_word = pbc_pkg::DATA_ZERO; // RULE_22
		stat_word[pbc_pkg::STA_ABIL_HI:pbc_pkg::STA_ABIL_LO] = pbc_pkg::STA_ABIL; // RULE_15
		stat_word[pbc_pkg::STA_AN_DONE] = an_cmpl; // RULE_16
		stat_word[pbc_pkg::STA_RFAULT]  = rf_latch; // RULE_17
		stat_word[pbc_pkg::STA_AN_ABLE] = 1'b1; // RULE_18
		stat_word[pbc_pkg::STA_LINK]    = link_latch; // RULE_19
		stat_word[pbc_pkg::STA_JABBER]  = jab_latch; // RULE_20
		stat_word[pbc_pkg::STA_EXT_CAP] = 1'b1; // RULE_21
	end

	// Answer one cycle after the strobe; unmapped indices read zero
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			MGMT_RD_DATA  <= pbc_pkg::DATA_ZERO;
			MGMT_RD_VALID <= 1'b0;
		end else begin
			MGMT_RD_VALID <= MGMT_RD_STB; // RULE_01
			if (MGMT_RD_STB) begin
				case (MGMT_INDEX)
					pbc_pkg::IDX_CTRL: MGMT_RD_DATA <= ctl_word; // RULE_02
					pbc_pkg::IDX_STAT: MGMT_RD_DATA <= stat_word; // RULE_02
					default:           MGMT_RD_DATA <= pbc_pkg::DATA_ZERO;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_srst_hold;
		SOFT_RESET_ACTIVE[*8];
	endsequence

	sequence s_rd_stat_answer;
		MGMT_RD_VALID && ($past(MGMT_INDEX) == pbc_pkg::IDX_STAT);
	endsequence

	sequence s_rd_ctl_answer;
		MGMT_RD_VALID && ($past(MGMT_INDEX) == pbc_pkg::IDX_CTRL);
	endsequence

	AST_SRST_HOLD: assert property (srst_start |=> s_srst_hold) // RULE_04
		else $error("soft reset dropped early");
	AST_SRST_END: assert property (srst_start |-> ##10 SOFT_RESET_ACTIVE ##1 !SOFT_RESET_ACTIVE) // RULE_04
		else $error("soft reset did not clear on time");
	AST_STRAP_KEPT: assert property (srst_start |=> strap_val == $past(strap_val)) // RULE_03
		else $error("strap value lost in soft reset");
	AST_STRAP_LOAD: assert property (srst_start |-> ##2 AN_ENABLE == strap_val) // RULE_09
		else $error("negotiation default not from strap");
	AST_LOOPBACK: assert property (wr_ctl && !MGMT_WR_DATA[15] |-> ##2
		LOOPBACK_EN == $past(MGMT_WR_DATA[14], 2)) // RULE_06
		else $error("loopback does not follow write");
	AST_COL_TEST: assert property (wr_ctl && !MGMT_WR_DATA[15] |-> ##2
		COL_TEST_EN == $past(MGMT_WR_DATA[7], 2)) // RULE_14
		else $error("collision test does not follow write");
	AST_PWRDN: assert property (wr_ctl && !MGMT_WR_DATA[15] |-> ##2
		POWER_DOWN == $past(MGMT_WR_DATA[11], 2)) // RULE_10
		else $error("power down does not follow write");
	AST_FORCE_IGN: assert property (AN_ENABLE |-> !FORCE_SPEED_100 && !FORCE_FULL_DUPLEX) // RULE_08
		else $error("forced mode active while negotiating");
	AST_FORCE_SPD: assert property (wr_ctl && !MGMT_WR_DATA[15] && !MGMT_WR_DATA[12] |-> ##2
		FORCE_SPEED_100 == $past(MGMT_WR_DATA[13], 2)
		&& FORCE_FULL_DUPLEX == $past(MGMT_WR_DATA[8], 2)) // RULE_07 RULE_13
		else $error("forced speed or duplex wrong");
	AST_RESTART: assert property (AN_RESTART && !(wr_ctl && MGMT_WR_DATA[9] // RULE_12
		&& !MGMT_WR_DATA[15]) |=> !AN_RESTART)
		else $error("restart did not self-clear");
	AST_AN_DONE: assert property (ctl_pwr || !ctl_an_en |=> !an_cmpl) // RULE_11 RULE_16
		else $error("completion shown while not negotiating");
	AST_ABILITY: assert property (s_rd_stat_answer |-> MGMT_RD_DATA[15:11] == 5'h0f
		&& MGMT_RD_DATA[10:6] == 5'h00 && MGMT_RD_DATA[3] && MGMT_RD_DATA[0]) // RULE_15
		else $error("fixed status bits wrong");
	AST_CTL_RSVD: assert property (s_rd_ctl_answer |-> MGMT_RD_DATA[10] == 1'b0
		&& MGMT_RD_DATA[6:0] == 7'h00) // RULE_22
		else $error("reserved control bits not zero");
	AST_RF_HOLD: assert property (rf_latch && !rd_stat && !srst_start |=> rf_latch) // RULE_17
		else $error("remote fault latch lost");
	AST_JAB_HOLD: assert property (jab_latch && !rd_stat && !srst_start |=> jab_latch) // RULE_20
		else $error("jabber latch lost");
	AST_LINK_LOW: assert property (!link_latch && !rd_stat |=> !link_latch) // RULE_19
		else $error("link latch rose without read");
	AST_REARM: assert property (rd_stat && !srst_start |=> rf_latch == $past(rf_live)
		&& link_latch == $past(link_live)) // RULE_22
		else $error("latch not re-armed after read");
endmodule : pbc_regs
`default_nettype wire

// ---- tb/pbc_mac_model.sv ----
// MAC side model of the indirect management access path to the PHY registers.
// Assumes REF_CLK comes from the bench; requests change just after falling edges.
`timescale 1ns/100ps
`default_nettype none
module pbc_mac_model (
	input  wire logic        REF_CLK,
	output logic      [4:0]  MGMT_INDEX,
	output logic             MGMT_WR_STB,
	output logic      [15:0] MGMT_WR_DATA,
	output logic             MGMT_RD_STB,
	input  wire logic [15:0] MGMT_RD_DATA,
	input  wire logic        MGMT_RD_VALID
);
	// ==========================================================
	// Idle bus
	initial begin
		MGMT_INDEX   = 5'h1f;
		MGMT_WR_STB  = 1'b0;
		MGMT_WR_DATA = 16'hffff;
		MGMT_RD_STB  = 1'b0;
	end

	// ==========================================================
	// Access tasks
	// Released index and data are inverted so a stale value never passes as valid
	task automatic wr(input logic [4:0] idx, input logic [15:0] data);
		@(negedge REF_CLK);
		MGMT_INDEX   = idx;
		MGMT_WR_DATA = data;
		MGMT_WR_STB  = 1'b1;
		@(negedge REF_CLK);
		MGMT_WR_STB  = 1'b0;
		MGMT_INDEX   = ~idx;
		MGMT_WR_DATA = ~data;
	endtask : wr

	// Read data is taken one edge after the strobe, where it is settled
	task automatic rd(input logic [4:0] idx, output logic [15:0] data, output logic vld);
		@(negedge REF_CLK);
		MGMT_INDEX  = idx;
		MGMT_RD_STB = 1'b1;
		@(negedge REF_CLK);
		MGMT_RD_STB = 1'b0;
		MGMT_INDEX  = ~idx;
		data        = MGMT_RD_DATA;
		vld         = MGMT_RD_VALID;
	endtask : rd

	// Soft reset request carries the reset bit alone
	task automatic soft_reset();
		wr(pbc_pkg::IDX_CTRL, 16'h8000);
	endtask : soft_reset
endmodule : pbc_mac_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the PHY basic control and status registers.
// Assumes the MAC model above drives all management accesses.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        ref_clk, rst, speed_strap, link_up_in, remote_fault_in, jabber_in, an_done_in;
	logic [4:0]  mgmt_index;
	logic        mgmt_wr_stb, mgmt_rd_stb, mgmt_rd_valid;
	logic [15:0] mgmt_wr_data, mgmt_rd_data, rdat;
	logic        rvld;
	logic        srst, loop_en, fspd, an_en, pd, an_rst, fdup, col;
	logic [7:0]  outs;
	int          num_errors, n_compared;
	localparam logic [15:0] ST_BASE = 16'h7809;
	localparam logic [15:0] ST_AN   = 16'h0020;
	localparam logic [15:0] ST_RF   = 16'h0010;
	localparam logic [15:0] ST_LNK  = 16'h0004;
	localparam logic [15:0] ST_JAB  = 16'h0002;

	// ==========================================================
	// Mode outputs packed in control bit order, bit 9 slot holds restart, bit 10 left out
	assign outs = {srst, loop_en, fspd, an_en, pd, an_rst, fdup, col};

	always #(pbc_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

	pbc_regs dut_u (.REF_CLK(ref_clk), .RST(rst), .MGMT_INDEX(mgmt_index),
		.MGMT_WR_STB(mgmt_wr_stb), .MGMT_WR_DATA(mgmt_wr_data), .MGMT_RD_STB(mgmt_rd_stb),
		.MGMT_RD_DATA(mgmt_rd_data), .MGMT_RD_VALID(mgmt_rd_valid), .SPEED_STRAP(speed_strap),
		.LINK_UP_IN(link_up_in), .REMOTE_FAULT_IN(remote_fault_in), .JABBER_IN(jabber_in),
		.AN_DONE_IN(an_done_in), .SOFT_RESET_ACTIVE(srst), .LOOPBACK_EN(loop_en),
		.FORCE_SPEED_100(fspd), .FORCE_FULL_DUPLEX(fdup), .AN_ENABLE(an_en),
		.AN_RESTART(an_rst), .POWER_DOWN(pd), .COL_TEST_EN(col));

	pbc_mac_model mac_u (.REF_CLK(ref_clk), .MGMT_INDEX(mgmt_index), .MGMT_WR_STB(mgmt_wr_stb),
		.MGMT_WR_DATA(mgmt_wr_data), .MGMT_RD_STB(mgmt_rd_stb), .MGMT_RD_DATA(mgmt_rd_data),
		.MGMT_RD_VALID(mgmt_rd_valid));

	// ==========================================================
	// Checking helpers
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Read must answer with a valid pulse as well as the word
	task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
		mac_u.rd(idx, rdat, rvld);
		check(16'(rvld), 16'h0001);
		check(rdat, exp);
	endtask : rd_chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	// Flags need time through the two-stage synchronisers
	task automatic pulse_flags(input logic rf, input logic jb, input logic lnk_drop);
		remote_fault_in = rf;
		jabber_in       = jb;
		if (lnk_drop) link_up_in = 1'b0;
		cyc(4);
		remote_fault_in = 1'b0;
		jabber_in       = 1'b0;
		link_up_in      = 1'b1;
		cyc(6);
	endtask : pulse_flags

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Watchdog, about twenty times the expected run
	initial begin
		#(pbc_pkg::CLK_PERIOD_NS * 3000);
		num_errors++;
		summarize();
	end

	// ==========================================================
	// Main sequence
	initial begin
		ref_clk = 1'b0; rst = 1'b1; speed_strap = 1'b1; link_up_in = 1'b0;
		remote_fault_in = 1'b0; jabber_in = 1'b0; an_done_in = 1'b0;
		num_errors = 0; n_compared = 0;
		cyc(10);
		rst = 1'b0;
		cyc(6);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h3000);
		check(16'(outs), 16'h0010);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE);
		// Reserved control bits ignore writes, forcing applies with negotiation off
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h6dff);
		cyc(1);
		check(16'(outs), 16'h006b);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h6980);
		// Writes elsewhere are dropped, unmapped reads return zero
		mac_u.wr(pbc_pkg::IDX_STAT, 16'hffff);
		mac_u.wr(5'h05, 16'hffff);
		rd_chk(5'h05, 16'h0000);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h6980);
		// Negotiation overrides forced speed and duplex
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h3100);
		cyc(1);
		check(16'(outs), 16'h0010);
		// Restart pulses once and self-clears
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h1200);
		check(16'(an_rst), 16'h0001);
		cyc(1);
		check(16'(an_rst), 16'h0000);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h1000);
		// Completion shows only while powered up
		an_done_in = 1'b1;
		cyc(6);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN);
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h1800);
		cyc(6);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE);
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h1000);
		cyc(6);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN);
		// Latched flags hold until read, then follow the live level
		pulse_flags(1'b1, 1'b1, 1'b0);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN | ST_RF | ST_JAB);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN | ST_LNK);
		pulse_flags(1'b0, 1'b0, 1'b1);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN);
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN | ST_LNK);
		// Soft reset: defaults from the captured strap, latches cleared
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h5880);
		pulse_flags(1'b0, 1'b1, 1'b0);
		speed_strap = 1'b0;
		mac_u.soft_reset();
		cyc(1);
		check(16'(outs), 16'h0090);
		rd_chk(pbc_pkg::IDX_CTRL, 16'hb000);
		mac_u.wr(pbc_pkg::IDX_CTRL, 16'h4000);
		cyc(10);
		check(16'(outs), 16'h0010);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h3000);
		// Soft reset left every latch cleared; link stays latched low until read
		rd_chk(pbc_pkg::IDX_STAT, ST_BASE | ST_AN);
		// Hard reset recaptures the strap
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(6);
		rd_chk(pbc_pkg::IDX_CTRL, 16'h0000);
		check(16'(outs), 16'h0000);
		summarize();
	end
endmodule : testbench
`default_nettype wire
